// file: inc/gpc_pkg.sv
package gpc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  GPC_IDX_PIN4      = 8'h77;
  localparam logic [7:0]  GPC_IDX_PIN5      = 8'h78;
  localparam logic [7:0]  GPC_IDX_IRQ_STAT  = 8'h79;
  localparam logic [7:0]  GPC_IDX_IRQ_MASK  = 8'h7A;
  localparam logic [11:0] GPC_ADDR_PIN4     = {2'b00, GPC_IDX_PIN4, 2'b00};
  localparam logic [11:0] GPC_ADDR_PIN5     = {2'b00, GPC_IDX_PIN5, 2'b00};
  localparam logic [11:0] GPC_ADDR_IRQ_STAT = {2'b00, GPC_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] GPC_ADDR_IRQ_MASK = {2'b00, GPC_IDX_IRQ_MASK, 2'b00};

  // Field positions
  localparam int GPC_FN_LSB  = 8;
  localparam int GPC_DIR_BIT = 7;
  localparam int GPC_OT_BIT  = 6;
  localparam int GPC_POL_BIT = 5;
  localparam int GPC_LVL_BIT = 4;
  localparam int GPC_PD_BIT  = 3;
  localparam int GPC_PU_BIT  = 2;
  localparam int GPC_TRG_BIT = 1;
  localparam int GPC_DB_BIT  = 0;
  localparam int GPC_IRQ4_BIT = 3;
  localparam int GPC_IRQ5_BIT = 4;

  localparam logic [15:0] GPC_CTRL_MASK = 16'h3FFF;
  localparam logic [15:0] GPC_IRQ_MASK_BITS = 16'h0018;

  // Reset values
  localparam logic [15:0] GPC_PIN4_RST     = 16'h0220;
  localparam logic [15:0] GPC_PIN5_RST     = 16'h01A0;
  localparam logic [15:0] GPC_IRQ_STAT_RST = 16'h0000;
  localparam logic [15:0] GPC_IRQ_MASK_RST = 16'h0018;

  // Debounce time and cycle count at 100 MHz
  localparam int GPC_CLK_MHZ       = 100;
  localparam int GPC_DEBOUNCE_US   = 10;
  localparam int GPC_DEBOUNCE_CYC  = GPC_DEBOUNCE_US * GPC_CLK_MHZ;

  typedef enum logic [5:0] {
    GPC_FN_SW_OUT   = 6'h00,
    GPC_FN_BCLK     = 6'h01,
    GPC_FN_IRQ_OUT  = 6'h02,
    GPC_FN_INPUT    = 6'h03,
    GPC_FN_BIAS_CUR = 6'h04,
    GPC_FN_BIAS_SC  = 6'h05,
    GPC_FN_LOCK     = 6'h08,
    GPC_FN_LOOP_CLK = 6'h09
  } gpc_fn_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [5:0] fn;
    logic       dir;
    logic       otype;
    logic       pol;
    logic       lvl;
    logic       pd;
    logic       pu;
    logic       trig;
    logic       db;
  } gpc_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
  } gpc_pad_t;

  typedef struct packed {
    logic bias_cur;
    logic bias_sc;
    logic lock;
    logic loop_clk;
    logic bclk;
  } gpc_src_t;
endpackage

// file: rtl/gpc_debounce.sv
`timescale 1ns/1ps
module gpc_debounce
  import gpc_pkg::*;
#(
  parameter int COUNT = GPC_DEBOUNCE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw,
  input  wire logic enable,
  output logic      level
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_r;
  logic          stable_r;

  // (RQ11) Stable-time filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= '0;
      stable_r <= 1'b0;
    end else if (raw == stable_r) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r    <= '0;
      stable_r <= raw;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Bypass keeps filter tracking so enabling it glitches only while raw and stable_r differ
  assign level = enable ? stable_r : raw;

  // (RQ11) Level moves after full count
  a_db_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    $changed(stable_r) |-> $past(cnt_r == LAST && raw != stable_r)) else $error("filter moved early");
endmodule

// file: rtl/gpc_pin.sv
`timescale 1ns/1ps
module gpc_pin
  import gpc_pkg::*;
#(
  parameter bit HAS_BCLK = 1'b0,
  parameter int DB_COUNT = GPC_DEBOUNCE_CYC
) (
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire gpc_ctrl_t ctrl,
  input  wire gpc_src_t  src,
  input  wire logic      irq_level,
  input  wire logic      pad_i,
  output gpc_pad_t       pad,
  output logic           event_p,
  output logic           active
);
  logic sync1_r, sync2_r, filt, prev_r, drive;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pad_i;
      sync2_r <= sync1_r;
    end
  end

  // (RQ8) Optional debounce
  gpc_debounce #(.COUNT(DB_COUNT)) u_db (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (sync2_r),
    .enable  (ctrl.db),
    .level   (filt)
  );

  // (RQ12) Polarity before detection
  assign active = ctrl.pol ? filt : ~filt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= active;
    end
  end

  // (RQ8) Level or edge trigger, input mode only
  assign event_p = ctrl.dir && (ctrl.fn == GPC_FN_INPUT) &&
                   (ctrl.trig ? (active && !prev_r) : active);

  // (RQ1) Function routing; reserved codes drive low
  always_comb begin
    case (ctrl.fn)
      GPC_FN_SW_OUT:   drive = ctrl.lvl;
      GPC_FN_BCLK:     drive = HAS_BCLK ? src.bclk : 1'b0;
      GPC_FN_IRQ_OUT:  drive = irq_level;
      GPC_FN_BIAS_CUR: drive = src.bias_cur;
      GPC_FN_BIAS_SC:  drive = src.bias_sc;
      GPC_FN_LOCK:     drive = src.lock;
      GPC_FN_LOOP_CLK: drive = src.loop_clk;
      // (RQ3) Reserved codes drive low
      default:         drive = 1'b0;
    endcase
  end

  // (RQ4) Direction and CMOS or open-drain drive
  assign pad.o  = ctrl.otype ? 1'b0 : drive;
  assign pad.oe = !ctrl.dir && (ctrl.otype ? !drive : 1'b1);
  // (RQ6) Pull-down enable
  assign pad.pd = ctrl.pd;
  // (RQ7) Pull-up enable
  assign pad.pu = ctrl.pu;
endmodule

// file: rtl/gpc_top.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Pin4 selector bits 13:8, reset 02h
// (RQ2) Pin5 same codes, 01h bit clock, reset 01h
// (RQ3) Reserved codes undefined; here drive low
// (RQ4) Pin4 level, direction, output type bits
// (RQ5) Pin5 level bit4; reset input, CMOS
// (RQ6) Bit3 enables weak pull-down
// (RQ7) Bit2 enables weak pull-up
// (RQ8) Polarity, trigger mode, debounce enable bits
// (RQ9) Status flags bits 3 and 4
// (RQ10) Pin5 event masked until mask cleared
// (RQ11) Debounce needs stable level for count
// (RQ12) Polarity applied before edge/level detect
module gpc_top
  import gpc_pkg::*;
#(
  parameter int DB_COUNT = GPC_DEBOUNCE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire gpc_src_t    src,
  input  wire logic        pin4_i,
  output gpc_pad_t         pin4_pad,
  input  wire logic        pin5_i,
  output gpc_pad_t         pin5_pad,
  output logic             irq
);
  gpc_ctrl_t   pin4_r, pin5_r;
  logic [15:0] stat_r, mask_r;
  logic [31:0] prdata_r;
  logic        wr_en, rd_en, hit;
  logic        ev4, ev5, act4, act5;
  logic [15:0] set_v;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign hit     = (paddr == GPC_ADDR_PIN4) || (paddr == GPC_ADDR_PIN5) ||
                   (paddr == GPC_ADDR_IRQ_STAT) || (paddr == GPC_ADDR_IRQ_MASK);
  // Unmapped address answers with an error, reads zero
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  // (RQ1) Pin4 control register with reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin4_r <= gpc_ctrl_t'(GPC_PIN4_RST);
    end else if (wr_en && paddr == GPC_ADDR_PIN4) begin
      pin4_r <= gpc_ctrl_t'(pwdata[15:0] & GPC_CTRL_MASK);
    end
  end

  // (RQ2) Pin5 control register, input after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin5_r <= gpc_ctrl_t'(GPC_PIN5_RST);
    end else if (wr_en && paddr == GPC_ADDR_PIN5) begin
      pin5_r <= gpc_ctrl_t'(pwdata[15:0] & GPC_CTRL_MASK);
    end
  end

  // (RQ9) Sticky flags; set wins over write-one clear
  always_comb begin
    set_v = '0;
    set_v[GPC_IRQ4_BIT] = ev4;
    set_v[GPC_IRQ5_BIT] = ev5;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= GPC_IRQ_STAT_RST;
    end else if (wr_en && paddr == GPC_ADDR_IRQ_STAT) begin
      stat_r <= (stat_r & ~pwdata[15:0]) | set_v;
    end else begin
      stat_r <= stat_r | set_v;
    end
  end

  // (RQ10) Mask resets to masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= GPC_IRQ_MASK_RST;
    end else if (wr_en && paddr == GPC_ADDR_IRQ_MASK) begin
      mask_r <= pwdata[15:0] & GPC_IRQ_MASK_BITS;
    end
  end

  // (RQ10) Only unmasked flags raise the output
  assign irq = |(stat_r & ~mask_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        GPC_ADDR_PIN4:     prdata_r <= {16'h0000, 16'(pin4_r)};
        GPC_ADDR_PIN5:     prdata_r <= {16'h0000, 16'(pin5_r)};
        GPC_ADDR_IRQ_STAT: prdata_r <= {16'h0000, stat_r};
        GPC_ADDR_IRQ_MASK: prdata_r <= {16'h0000, mask_r};
        default:           prdata_r <= '0;
      endcase
    end
  end

  // (RQ4) Pin4 drive, no bit clock
  gpc_pin #(.HAS_BCLK(1'b0), .DB_COUNT(DB_COUNT)) u_pin4 (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl      (pin4_r),
    .src       (src),
    .irq_level (irq),
    .pad_i     (pin4_i),
    .pad       (pin4_pad),
    .event_p   (ev4),
    .active    (act4)
  );

  // (RQ5) Pin5 drive with bit clock option
  gpc_pin #(.HAS_BCLK(1'b1), .DB_COUNT(DB_COUNT)) u_pin5 (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl      (pin5_r),
    .src       (src),
    .irq_level (irq),
    .pad_i     (pin5_i),
    .pad       (pin5_pad),
    .event_p   (ev5),
    .active    (act5)
  );

  // Helper: pin5 event seen last cycle
  logic ev5_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev5_d_r <= 1'b0;
    end else begin
      ev5_d_r <= ev5;
    end
  end

  // (RQ9) Flag follows event
  a_flag_sets4: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    ev4 |=> stat_r[GPC_IRQ4_BIT]) else $error("pin4 flag not set");
  // (RQ9) Flag follows event
  a_flag_sets5: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    ev5 |=> stat_r[GPC_IRQ5_BIT]) else $error("pin5 flag not set");
  // (RQ10) Masked flag silent
  a_mask_gates: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (mask_r[GPC_IRQ5_BIT] && stat_r == 16'h0010) |-> !irq) else $error("masked flag raised irq");
  // (RQ10) Unmasked flag raises
  a_irq_unmask: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (ev5_d_r && !mask_r[GPC_IRQ5_BIT]) |-> irq) else $error("unmasked flag lost");
  // (RQ4) Software level driven
  a_sw_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (pin4_r.fn == 6'h00 && !pin4_r.dir && !pin4_r.otype) |-> (pin4_pad.oe && pin4_pad.o == pin4_r.lvl))
    else $error("pin4 level not driven");
  // (RQ5) Input stays undriven
  a_input_hiz: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    pin5_r.dir |-> !pin5_pad.oe) else $error("input pin driven");
  // (RQ2) Bit clock routed
  a_bclk_route: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (pin5_r.fn == 6'h01 && !pin5_r.otype) |-> pin5_pad.o == src.bclk) else $error("bclk not routed");
  // (RQ3) Reserved code low
  a_pin4_nobclk: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (pin4_r.fn == 6'h01) |-> !pin4_pad.o) else $error("reserved code drove high");
  // (RQ6) Pull-down passes
  a_pull_dn: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    pin4_pad.pd == pin4_r.pd && pin5_pad.pd == pin5_r.pd) else $error("pull-down mismatch");
  // (RQ7) Pull-up passes
  a_pull_up: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    pin4_pad.pu == pin4_r.pu && pin5_pad.pu == pin5_r.pu) else $error("pull-up mismatch");
  // (RQ12) One event per edge; settings unchanged
  a_edge_once: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    (pin5_r.trig && ev5 ##1 $stable(pin5_r)) |-> !ev5) else $error("edge event repeated");
  // (RQ1) Interrupt routed out
  a_irq_pin: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (pin4_r.fn == 6'h02 && !pin4_r.otype) |-> pin4_pad.o == irq) else $error("irq not routed");
  // (RQ8) Level event needs active
  a_db_polar: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    (ev4 && !pin4_r.trig) |-> act4) else $error("event without active level");
endmodule

// file: verif/gpc_board_model.sv
`timescale 1ns/1ps
module gpc_board_model
  import gpc_pkg::*;
(
  input  wire logic     pclk,
  input  wire gpc_pad_t pad,
  input  wire logic     ext_en,
  input  wire logic     ext_val,
  output logic          level
);
  logic flip_r = 1'b0;

  // Floating node wanders so no stale level is trusted
  always_ff @(posedge pclk) begin
    flip_r <= ~flip_r;
  end

  // Device driver wins over the board source
  always_comb begin
    if (pad.oe) level = pad.o;
    else if (ext_en) level = ext_val;
    else if (pad.pu) level = 1'b1;
    else if (pad.pd) level = 1'b0;
    else level = flip_r;
  end
endmodule

// file: verif/gpc_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, x, g); end end
module gpc_top_tb_top
  import gpc_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d;
    gpc_src_t    s;
    gpc_pad_t    p;
  } gpc_row_t;

  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e, pin4_i, pin5_i, ext4, ext5;
  gpc_src_t    src;
  gpc_pad_t    pin4_pad, pin5_pad;
  int          fail_count = 0;
  int          tests_run = 0;
  gpc_row_t    rows [17] = '{
    {GPC_ADDR_PIN4, 16'h0010, 5'h00, 4'hC}, {GPC_ADDR_PIN4, 16'h0000, 5'h1F, 4'h4},
    {GPC_ADDR_PIN4, 16'h0400, 5'h10, 4'hC}, {GPC_ADDR_PIN4, 16'h0500, 5'h08, 4'hC},
    {GPC_ADDR_PIN4, 16'h0800, 5'h04, 4'hC}, {GPC_ADDR_PIN4, 16'h0900, 5'h02, 4'hC},
    {GPC_ADDR_PIN4, 16'h0908, 5'h00, 4'h5}, {GPC_ADDR_PIN4, 16'h0004, 5'h00, 4'h6},
    {GPC_ADDR_PIN4, 16'h0050, 5'h00, 4'h0}, {GPC_ADDR_PIN4, 16'h0040, 5'h00, 4'h4},
    {GPC_ADDR_PIN4, 16'h0100, 5'h1F, 4'h4}, {GPC_ADDR_PIN4, 16'h0090, 5'h00, 4'h8},
    {GPC_ADDR_PIN5, 16'h0100, 5'h01, 4'hC}, {GPC_ADDR_PIN5, 16'h0010, 5'h00, 4'hC},
    {GPC_ADDR_PIN5, 16'h0600, 5'h1F, 4'h4}, {GPC_ADDR_PIN5, 16'h0200, 5'h00, 4'h4},
    {GPC_ADDR_PIN5, 16'h03A0, 5'h00, 4'h0}};

  always #5 pclk = ~pclk;

  gpc_top #(.DB_COUNT(4)) i_gpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src), .pin4_i(pin4_i), .pin4_pad(pin4_pad), .pin5_i(pin5_i), .pin5_pad(pin5_pad), .irq(irq));
  gpc_board_model i_board4 (.pclk(pclk), .pad(pin4_pad), .ext_en(1'b1), .ext_val(ext4), .level(pin4_i));
  gpc_board_model i_board5 (.pclk(pclk), .pad(pin5_pad), .ext_en(1'b1), .ext_val(ext5), .level(pin5_i));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
    // Outputs settle after the write edge
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, {16'h0000, x}, q)
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, src, ext4, ext5, presetn} = '0;
    ext4 = 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("pin4 pad rst", 4'h4, pin4_pad)
    `CHK("pin5 pad rst", 4'h0, pin5_pad)
    presetn <= 1'b1;
    rd(GPC_ADDR_PIN4, 16'h0220, "pin4 rst");
    rd(GPC_ADDR_PIN5, 16'h01A0, "pin5 rst");
    rd(GPC_ADDR_IRQ_STAT, 16'h0000, "stat rst");
    rd(GPC_ADDR_IRQ_MASK, 16'h0018, "mask rst");
    $display("Test reset done");
    foreach (rows[i]) begin
      src <= rows[i].s;
      wr(rows[i].a, rows[i].d);
      `CHK("pad row", rows[i].p, (rows[i].a == GPC_ADDR_PIN4) ? pin4_pad : pin5_pad)
    end
    $display("Test pad rows done");
    // Edge mode: one flag per rising edge, masked until cleared
    wr(GPC_ADDR_PIN5, 16'h03A2);
    wr(GPC_ADDR_IRQ_STAT, 16'h0018);
    ext5 <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(GPC_ADDR_IRQ_STAT, 16'h0010, "pin5 flag");
    `CHK("irq masked", 1'b0, irq)
    wr(GPC_ADDR_IRQ_MASK, 16'h0008);
    `CHK("irq unmasked", 1'b1, irq)
    wr(GPC_ADDR_PIN4, 16'h0200);
    `CHK("pin4 irq out", 4'hC, pin4_pad)
    wr(GPC_ADDR_IRQ_STAT, 16'h0010);
    rd(GPC_ADDR_IRQ_STAT, 16'h0000, "edge cleared");
    `CHK("irq cleared", 1'b0, irq)
    $display("Test interrupt done");
    // Active low, level mode, debounced: short glitch is dropped
    wr(GPC_ADDR_PIN4, 16'h0381);
    // Filter must settle first; stale low level still raises events
    repeat (8) @(posedge pclk);
    wr(GPC_ADDR_IRQ_STAT, 16'h0018);
    ext4 <= 1'b0;
    repeat (2) @(posedge pclk);
    ext4 <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(GPC_ADDR_IRQ_STAT, 16'h0000, "glitch");
    ext4 <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(GPC_ADDR_IRQ_STAT, 16'h0008, "pin4 flag");
    $display("Test debounce done");
    apb(1'b1, 12'h100, 32'h0000_FFFF);
    `CHK("unmapped err", 1'b1, e)
    rd(12'h100, 16'h0000, "unmapped rd");
    `CHK("unmapped rd err", 1'b1, e)
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(GPC_ADDR_PIN4, 16'h0220, "pin4 rst again");
    rd(GPC_ADDR_PIN5, 16'h01A0, "pin5 rst again");
    rd(GPC_ADDR_IRQ_STAT, 16'h0000, "stat rst again");
    rd(GPC_ADDR_IRQ_MASK, 16'h0018, "mask rst again");
    `CHK("irq rst again", 1'b0, irq)
    $display("Test bus and second reset done");
    conclude();
  end
endmodule
